// ---- verilog/mcu4_instr_ctl.sv ----
// instruction control: swaps, status and carry flags, conditional transfers
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`default_nettype none
module mcu4_instr_ctl
  import mcu4_ctl_pkg::*;
(
  input  wire logic              clk_in,        // core clock
  input  wire logic              nrst_in,       // async reset, active low
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr_in,   // register address
  input  wire logic [DATA_W-1:0] reg_wdata_in,  // write data
  input  wire logic              reg_wr_in,     // write strobe
  input  wire logic              reg_rd_in,     // read strobe
  output var  logic [DATA_W-1:0] reg_rdata_out, // read data, next cycle
  // instruction and datapath
  input  wire instr_t            instr_in,      // current instruction
  input  wire alu_flags_t        alu_in,        // its datapath results
  output var  logic              instr_ack_out, // instruction consumed
  output var  logic              busy_out,      // pattern second cycle
  output var  logic [NIB_W-1:0]  x_out,         // x address register
  output var  logic [NIB_W-1:0]  y_out,         // y address register
  output var  logic [NIB_W-1:0]  x_spare_out,   // x_spare_reg
  output var  logic [NIB_W-1:0]  y_spare_out,   // y_spare_reg
  output var  logic              status_out,    // status flag-flop
  output var  logic              carry_out,     // carry flag-flop
  output var  logic [NIB_W-1:0]  pc_upper_out,  // upper program counter
  output var  logic              jump_out,      // branch or call taken
  output var  logic              seq_next_out   // sequential advance
);
  // ==========================================================
  // decode helpers
  // ==========================================================
  // true for the three conditional transfers
  function automatic logic is_cond_xfer(input op_t op);
    return (op == OP_BRANCH) || (op == OP_CALL) || (op == OP_LOAD_PCU);
  endfunction : is_cond_xfer

  // true for the eight ops that may touch the carry
  function automatic logic is_carry_op(input op_t op);
    unique case (op)
      OP_ADD_MEM_CARRY, OP_SUB_MEM_BORR, OP_DEC_ADJ_ADD, OP_DEC_ADJ_SUB,
      OP_SET_CARRY, OP_CLR_CARRY, OP_ROT_LEFT, OP_ROT_RIGHT:
        return 1'b1;
      default:
        return 1'b0;
    endcase
  endfunction : is_carry_op

  // ==========================================================
  // state
  // ==========================================================
  logic       run_ff;    // software run enable
  logic       tick;      // instruction-cycle enable pulse
  seq_t       seq_ff;    // sequencer state
  logic       exec;      // an instruction completes this cycle
  logic       wr_xy;     // software load of x and y
  logic       wr_spare;  // software load of spares
  instr_t     cur;       // shorthand for the instruction
  logic       nxt_status;

  assign cur      = instr_in;
  assign wr_xy    = reg_wr_in && (reg_addr_in == REG_XY);
  assign wr_spare = reg_wr_in && (reg_addr_in == REG_SPARE);
  // pattern op completes only on its second tick
  assign exec     = tick && run_ff &&
                    ((seq_ff == ST_PAT2) || (cur.op != OP_PATTERN));

  // ==========================================================
  // instruction-cycle divider
  // ==========================================================
  inst_cycle_div u_div (
    .clk_in   (clk_in),
    .nrst_in  (nrst_in),
    .run_in   (run_ff),
    .tick_out (tick)
  );

  // ==========================================================
  // control register
  // ==========================================================
  // run bit gates the whole sequencer
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      run_ff <= RUN_RST;
    end else if (reg_wr_in && (reg_addr_in == REG_CTRL)) begin
      run_ff <= reg_wdata_in[CTRL_RUN_BIT];
    end
  end

  // ==========================================================
  // sequencer
  // ==========================================================
  // pattern op holds the input for a second cycle; fetch stage must
  // keep instr_in stable until instr_ack_out
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      seq_ff <= ST_EXEC;
    end else if (tick && run_ff) begin
      unique case (seq_ff)
        ST_EXEC: begin
          if (cur.op == OP_PATTERN) begin
            seq_ff <= ST_PAT2;
          end
        end
        ST_PAT2: begin
          seq_ff <= ST_EXEC;
        end
      endcase
    end
  end

  // handshake outputs
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      instr_ack_out <= 1'b0;
      busy_out      <= 1'b0;
    end else begin
      instr_ack_out <= exec;
      busy_out      <= (seq_ff == ST_EXEC) ? (tick && run_ff &&
                       cur.op == OP_PATTERN) : !(tick && run_ff);
    end
  end

  // ==========================================================
  // address registers and their spares
  // ==========================================================
  // swap happens after the access, so the datapath sees old x, y
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      x_out       <= NIB_ZERO;
      x_spare_out <= NIB_ZERO;
    end else if (exec && cur.op == OP_RAM &&
                 (cur.sfx == SFX_X || cur.sfx == SFX_XY)) begin
      x_out       <= x_spare_out;
      x_spare_out <= x_out;
    end else begin
      // software load loses to an executing swap
      if (wr_xy) begin
        x_out <= reg_wdata_in[NIB_W-1:0];
      end
      if (wr_spare) begin
        x_spare_out <= reg_wdata_in[NIB_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      y_out       <= NIB_ZERO;
      y_spare_out <= NIB_ZERO;
    end else if (exec && cur.op == OP_RAM &&
                 (cur.sfx == SFX_Y || cur.sfx == SFX_XY)) begin
      y_out       <= y_spare_out;
      y_spare_out <= y_out;
    end else begin
      if (wr_xy) begin
        y_out <= reg_wdata_in[HI_LSB +: NIB_W];
      end
      if (wr_spare) begin
        y_spare_out <= reg_wdata_in[HI_LSB +: NIB_W];
      end
    end
  end

  // ==========================================================
  // status flag-flop
  // ==========================================================
  // judgement ops and add/subtract with carry or borrow replace status; others leave it alone
  always_comb begin
    nxt_status = status_out;
    unique case (cur.op)
      OP_TEST_NZ:       nxt_status = alu_in.nonzero;
      OP_TEST_C,
      OP_ADD_MEM_CARRY: nxt_status = alu_in.carry;
      OP_TEST_NB,
      OP_SUB_MEM_BORR:  nxt_status = alu_in.no_borrow;
      OP_TEST_BIT:      nxt_status = alu_in.test_bit;
      default:          nxt_status = status_out;
    endcase
  end

  // status is undefined on the real part; cleared here for determinism
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      status_out <= 1'b0;
    end else if (exec) begin
      status_out <= nxt_status;
    end
  end

  // ==========================================================
  // carry flag-flop
  // ==========================================================
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      carry_out <= 1'b0;
    end else if (exec && is_carry_op(cur.op)) begin
      unique case (cur.op)
        OP_SET_CARRY: carry_out <= 1'b1;
        OP_CLR_CARRY: carry_out <= 1'b0;
        default:      carry_out <= alu_in.new_carry;
      endcase
    end
  end

  // ==========================================================
  // conditional transfers
  // ==========================================================
  // status sampled as it stands before this instruction's update
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pc_upper_out <= NIB_ZERO;
    end else if (exec && cur.op == OP_LOAD_PCU && status_out) begin
      pc_upper_out <= cur.imm;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      jump_out     <= 1'b0;
      seq_next_out <= 1'b0;
    end else begin
      // upper-counter load is not itself a jump
      jump_out     <= exec && status_out && is_cond_xfer(cur.op) &&
                      (cur.op != OP_LOAD_PCU);
      seq_next_out <= exec && !(status_out && is_cond_xfer(cur.op) &&
                      (cur.op != OP_LOAD_PCU));
    end
  end

  // ==========================================================
  // register read port
  // ==========================================================
  // data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reg_rdata_out <= DATA_ZERO;
    end else if (reg_rd_in) begin
      reg_rdata_out <= DATA_ZERO;
      unique case (reg_addr_in)
        REG_CTRL:  reg_rdata_out[CTRL_RUN_BIT] <= run_ff;
        REG_XY:    reg_rdata_out <= {y_out, x_out};
        REG_SPARE: reg_rdata_out <= {y_spare_out, x_spare_out};
        REG_FLAGS: begin
          reg_rdata_out[FLG_STAT_BIT]  <= status_out;
          reg_rdata_out[FLG_CARRY_BIT] <= carry_out;
          reg_rdata_out[FLG_BUSY_BIT]  <= (seq_ff == ST_PAT2);
          reg_rdata_out[FLG_PCU_LSB +: NIB_W] <= pc_upper_out;
        end
        default:   reg_rdata_out <= DATA_ZERO; // unmapped reads zero
      endcase
    end else begin
      reg_rdata_out <= DATA_ZERO;
    end
  end
endmodule : mcu4_instr_ctl
`default_nettype wire

// ---- shared/mcu4_ctl_pkg.sv ----
// package: opcodes, carriers, register map and timing of the control core
`default_nettype none
package mcu4_ctl_pkg;
  // ==========================================================
  // timing
  // ==========================================================
  localparam int CLK_PERIOD_NS = 10;     // core clock period
  localparam int T_INST_NS     = 10000;  // one instruction cycle
  // longest time: rounds down, never below one cycle
  localparam int CYC_DIV_RAW   = T_INST_NS / CLK_PERIOD_NS;
  localparam int CYC_DIV       = (CYC_DIV_RAW < 1) ? 1 : CYC_DIV_RAW;
  localparam int DIV_W         = 10;     // divider counter width
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CYC_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_ZERO = 10'h000;

  // ==========================================================
  // widths and reset values
  // ==========================================================
  localparam int NIB_W  = 4;             // 4-bit datapath
  localparam int ADDR_W = 3;             // register port address
  localparam int DATA_W = 8;             // register port data
  localparam logic [NIB_W-1:0]  NIB_ZERO  = 4'h0;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic              RUN_RST   = 1'b0;

  // ==========================================================
  // register map
  // ==========================================================
  localparam logic [ADDR_W-1:0] REG_CTRL  = 3'h0; // bit0 run
  localparam logic [ADDR_W-1:0] REG_XY    = 3'h1; // [7:4] y, [3:0] x
  localparam logic [ADDR_W-1:0] REG_SPARE = 3'h2; // [7:4] y sp, [3:0] x sp
  localparam logic [ADDR_W-1:0] REG_FLAGS = 3'h3; // flags and pc upper
  localparam int CTRL_RUN_BIT  = 0;
  localparam int FLG_STAT_BIT  = 0;
  localparam int FLG_CARRY_BIT = 1;
  localparam int FLG_BUSY_BIT  = 2;
  localparam int FLG_PCU_LSB   = 4;
  localparam int HI_LSB        = 4;      // upper nibble of a byte

  // ==========================================================
  // instruction classes
  // ==========================================================
  typedef enum logic [4:0] {
    OP_NOP          = 5'h00,
    OP_RAM          = 5'h01, // ram access, suffix applies
    OP_TEST_NZ      = 5'h02, // alu_nonzero_cond
    OP_TEST_C       = 5'h03, // carry out of an add
    OP_TEST_NB      = 5'h04, // no_borrow_cond
    OP_TEST_BIT     = 5'h05, // bit, pin or flag straight in
    OP_ADD_MEM_CARRY= 5'h06, // add_mem_with_carry
    OP_SUB_MEM_BORR = 5'h07, // sub_mem_with_borrow
    OP_DEC_ADJ_ADD  = 5'h08, // decimal_adjust_add
    OP_DEC_ADJ_SUB  = 5'h09, // decimal_adjust_sub
    OP_SET_CARRY    = 5'h0A, // set_carry_op
    OP_CLR_CARRY    = 5'h0B, // clear_carry_op
    OP_ROT_LEFT     = 5'h0C, // rotate_left_op
    OP_ROT_RIGHT    = 5'h0D, // rotate_right_op
    OP_BRANCH       = 5'h0E, // cond_branch_op
    OP_CALL         = 5'h0F, // conditional subroutine jump
    OP_LOAD_PCU     = 5'h10, // load_pc_upper_op
    OP_PATTERN      = 5'h11  // two-cycle pattern generation
  } op_t;

  // swap suffix on ram access
  typedef enum logic [1:0] {
    SFX_NONE = 2'h0,
    SFX_X    = 2'h1,
    SFX_Y    = 2'h2,
    SFX_XY   = 2'h3
  } sfx_t;

  // instruction word as presented by the fetch stage
  typedef struct packed {
    op_t              op;
    sfx_t             sfx;
    logic [NIB_W-1:0] imm;   // page value for the upper counter load
  } instr_t;

  // datapath results of the current instruction
  typedef struct packed {
    logic nonzero;   // alu result not zero
    logic carry;     // add overflow
    logic no_borrow; // subtract without borrow
    logic test_bit;  // tested bit, pin or flag
    logic new_carry; // carry result of the carry-changing ops
  } alu_flags_t;

  // execution sequencer, gray along exec -> pattern second cycle
  typedef enum logic [1:0] {
    ST_EXEC = 2'b00,
    ST_PAT2 = 2'b01
  } seq_t;
endpackage : mcu4_ctl_pkg
`default_nettype wire

// ---- verilog/inst_cycle_div.sv ----
// divider that makes the one-cycle instruction-cycle enable pulse
`default_nettype none
module inst_cycle_div
  import mcu4_ctl_pkg::*;
(
  input  wire logic clk_in,   // core clock
  input  wire logic nrst_in,  // async reset, active low
  input  wire logic run_in,   // counting enabled
  output var  logic tick_out  // one-cycle pulse per instruction cycle
);
  // ==========================================================
  // counter
  // ==========================================================
  logic [DIV_W-1:0] cnt_ff; // cycles into the current instruction

  // held at zero while stopped so the first cycle is a full one
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_ff   <= DIV_ZERO;
      tick_out <= 1'b0;
    end else if (!run_in) begin
      cnt_ff   <= DIV_ZERO;
      tick_out <= 1'b0;
    end else if (cnt_ff == DIV_LAST) begin
      cnt_ff   <= DIV_ZERO;
      tick_out <= 1'b1;
    end else begin
      cnt_ff   <= cnt_ff + DIV_W'(1);
      tick_out <= 1'b0;
    end
  end
endmodule : inst_cycle_div
`default_nettype wire

// ---- sim/mcu4_instr_ctl_props.sv ----
// checker: port assertions of the instruction control block
`default_nettype none
module mcu4_instr_ctl_chk
  import mcu4_ctl_pkg::*;
(
  input wire logic              clk_in,        // core clock
  input wire logic              nrst_in,       // async reset, low
  input wire logic [ADDR_W-1:0] reg_addr_in,   // register address
  input wire logic [DATA_W-1:0] reg_wdata_in,  // write data
  input wire logic              reg_wr_in,     // write strobe
  input wire logic              reg_rd_in,     // read strobe
  input wire logic [DATA_W-1:0] reg_rdata_out, // read data
  input wire instr_t            instr_in,      // held instruction
  input wire alu_flags_t        alu_in,        // datapath results
  input wire logic              instr_ack_out,
  input wire logic              busy_out,
  input wire logic [NIB_W-1:0]  x_out,
  input wire logic [NIB_W-1:0]  y_out,
  input wire logic [NIB_W-1:0]  x_spare_out,
  input wire logic [NIB_W-1:0]  y_spare_out,
  input wire logic              status_out,
  input wire logic              carry_out,
  input wire logic [NIB_W-1:0]  pc_upper_out,
  input wire logic              jump_out,
  input wire logic              seq_next_out
);
  // ====================
  // clocking
  // ====================
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  // ====================
  // assertions
  // ====================
  // instr_in is still held in the ack cycle, so it names the op executed
  chk_swap_x_only: assert property (
    $changed(x_out) && !$past(reg_wr_in) |-> $past(instr_in.op) == OP_RAM
      && $past(instr_in.sfx[0]) && x_out == $past(x_spare_out))
    else $error("x changed without a swap");
  chk_swap_y_done: assert property (
    instr_ack_out && instr_in.op == OP_RAM && instr_in.sfx[1]
      |-> y_out == $past(y_spare_out) && y_spare_out == $past(y_out))
    else $error("y swap missing");
  chk_status_nonzero: assert property (
    instr_ack_out && instr_in.op == OP_TEST_NZ
      |-> status_out == $past(alu_in.nonzero))
    else $error("status not nonzero result");
  chk_status_carry: assert property (
    instr_ack_out && instr_in.op == OP_TEST_C
      |-> status_out == $past(alu_in.carry))
    else $error("status not carry");
  chk_status_noborrow: assert property (
    instr_ack_out && instr_in.op == OP_TEST_NB
      |-> status_out == $past(alu_in.no_borrow))
    else $error("status not no-borrow");
  chk_status_bit: assert property (
    instr_ack_out && instr_in.op == OP_TEST_BIT
      |-> status_out == $past(alu_in.test_bit))
    else $error("status not tested bit");
  chk_carry_eight: assert property (
    $changed(carry_out) |-> $past(instr_in.op) inside {OP_ADD_MEM_CARRY,
      OP_SUB_MEM_BORR, OP_DEC_ADJ_ADD, OP_DEC_ADJ_SUB, OP_SET_CARRY,
      OP_CLR_CARRY, OP_ROT_LEFT, OP_ROT_RIGHT})
    else $error("carry changed by other op");
  chk_jump_status: assert property (
    instr_ack_out && instr_in.op inside {OP_BRANCH, OP_CALL}
      |-> jump_out == $past(status_out) && seq_next_out != jump_out)
    else $error("transfer does not follow status");
  chk_pcu_load: assert property (
    $changed(pc_upper_out) |-> $past(instr_in.op) == OP_LOAD_PCU
      && $past(status_out) && pc_upper_out == $past(instr_in.imm))
    else $error("upper counter loaded wrongly");
  chk_busy_pattern: assert property (
    $rose(busy_out) |-> $past(instr_in.op) == OP_PATTERN && !instr_ack_out)
    else $error("busy without pattern");
  chk_ack_spacing: assert property (
    instr_ack_out |=> !instr_ack_out [*8])
    else $error("acks too close");
  chk_read_idle: assert property (
    !$past(reg_rd_in) || $past(reg_addr_in) > REG_FLAGS
      |-> reg_rdata_out == DATA_ZERO)
    else $error("read data outside its slot");

  // main scenarios reached
  cov_jump: cover property (jump_out);
  cov_pattern: cover property ($fell(busy_out));
  cov_pcu: cover property (instr_ack_out && instr_in.op == OP_LOAD_PCU);
endmodule : mcu4_instr_ctl_chk

bind mcu4_instr_ctl mcu4_instr_ctl_chk chk_i (
  .clk_in, .nrst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
  .reg_rdata_out, .instr_in, .alu_in, .instr_ack_out, .busy_out, .x_out,
  .y_out, .x_spare_out, .y_spare_out, .status_out, .carry_out,
  .pc_upper_out, .jump_out, .seq_next_out
);
`default_nettype wire

// ---- sim/test_mcu4_instruction_status_control.sv ----
// testbench: instruction control block against a reference model
`default_nettype none
module test_mcu4_instruction_status_control
  import mcu4_ctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ====================
  // signals and model
  // ====================
  logic              clk_in;
  logic              nrst_in;
  logic [ADDR_W-1:0] reg_addr_in;
  logic [DATA_W-1:0] reg_wdata_in, reg_rdata_out;
  logic              reg_wr_in, reg_rd_in;
  instr_t            instr_in;
  alu_flags_t        alu_in;
  logic              instr_ack_out, busy_out, jump_out, seq_next_out;
  logic              status_out, carry_out;
  logic [NIB_W-1:0]  x_out, y_out, x_spare_out, y_spare_out, pc_upper_out;
  int                failures = 0;  // mismatches
  int                checked = 0;   // comparisons
  int                cyc = 0;       // free-running cycle count
  int                last_ack = 0;  // cycle of the previous ack
  int unsigned       rng = 18;      // xorshift state
  bit [NIB_W-1:0]    mx, my, mxs, mys, mpcu; // model registers
  bit                mst, mc, known;         // model flags
  logic [7:0]        v;
  op_t               op;

  mcu4_instr_ctl DUT (
    .clk_in, .nrst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .instr_in, .alu_in, .instr_ack_out, .busy_out, .x_out,
    .y_out, .x_spare_out, .y_spare_out, .status_out, .carry_out,
    .pc_upper_out, .jump_out, .seq_next_out
  );

  // clock and cycle count
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) cyc <= cyc + 1;

  // ====================
  // helpers
  // ====================
  function automatic int unsigned next_rand();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : next_rand

  task automatic check(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : check

  task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_wr_in    <= 1'b1;
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_wr_in    <= 1'b0;
  endtask : reg_write

  // data stands only in the cycle after the strobe
  task automatic reg_read(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_in);
    reg_rd_in   <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_rd_in   <= 1'b0;
    #1 d = reg_rdata_out;
  endtask : reg_read

  task automatic check_regs();
    logic [7:0] d;
    reg_read(REG_XY, d);
    check("xy", d, {my, mx});
    reg_read(REG_SPARE, d);
    check("spare", d, {mys, mxs});
    reg_read(REG_FLAGS, d);
    check("flags", d & 8'hF6, {mpcu, 2'b00, mc, 1'b0});
    if (known) check("flag_st", 8'(d[0]), 8'(mst));
  endtask : check_regs

  // one instruction held until its ack, then model and compare
  task automatic exec(input op_t o, input alu_flags_t f);
    instr_t ins;
    bit     pre;
    bit     tk;
    logic   seen_busy;
    int     n;
    ins = '{op: o, sfx: sfx_t'(2'(next_rand())), imm: 4'(next_rand())};
    @(posedge clk_in);
    instr_in <= ins;
    alu_in   <= f;
    seen_busy = 1'b0;
    n = 0;
    do begin
      @(posedge clk_in);
      #1 seen_busy |= busy_out;
      n++;
    end while (instr_ack_out !== 1'b1 && n < 3000);
    check("ack", 8'(instr_ack_out), 8'h01);
    check("busy", 8'(seen_busy), 8'(o == OP_PATTERN));
    if (last_ack > 0) check("span", 8'(cyc - last_ack ==
      CYC_DIV * ((o == OP_PATTERN) ? 2 : 1)), 8'h01);
    last_ack = cyc;
    pre = mst;
    case (o)
      OP_RAM: begin
        if (ins.sfx[0]) {mx, mxs} = {mxs, mx};
        if (ins.sfx[1]) {my, mys} = {mys, my};
      end
      OP_TEST_NZ: mst = f.nonzero;
      OP_TEST_C: mst = f.carry;
      OP_TEST_NB: mst = f.no_borrow;
      OP_TEST_BIT: mst = f.test_bit;
      OP_ADD_MEM_CARRY: {mst, mc} = {f.carry, f.new_carry};
      OP_SUB_MEM_BORR: {mst, mc} = {f.no_borrow, f.new_carry};
      OP_DEC_ADJ_ADD, OP_DEC_ADJ_SUB, OP_ROT_LEFT, OP_ROT_RIGHT:
        mc = f.new_carry;
      OP_SET_CARRY: mc = 1'b1;
      OP_CLR_CARRY: mc = 1'b0;
      OP_LOAD_PCU: if (pre) mpcu = ins.imm;
      default: ;
    endcase
    if (o inside {OP_TEST_NZ, OP_TEST_C, OP_TEST_NB, OP_TEST_BIT,
                  OP_ADD_MEM_CARRY, OP_SUB_MEM_BORR}) known = 1'b1;
    check("x", 8'(x_out), 8'(mx));
    check("y", 8'(y_out), 8'(my));
    check("xs", 8'(x_spare_out), 8'(mxs));
    check("ys", 8'(y_spare_out), 8'(mys));
    if (known) check("status", 8'(status_out), 8'(mst));
    check("carry", 8'(carry_out), 8'(mc));
    check("pcu", 8'(pc_upper_out), 8'(mpcu));
    // every op pulses exactly one of jump and sequential advance
    tk = pre && (o == OP_BRANCH || o == OP_CALL);
    check("jump", 8'(jump_out), 8'(tk));
    check("seq", 8'(seq_next_out), 8'(!tk));
    if (o inside {OP_BRANCH, OP_CALL, OP_LOAD_PCU}) begin
      known = 1'b0;  // status after a transfer is left unpredicted
    end
  endtask : exec

  task automatic print_verdict();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  // ====================
  // watchdog and main sequence
  // ====================
  initial begin
    repeat (90000) @(posedge clk_in);
    failures++;
    print_verdict();
  end

  initial begin
    nrst_in = 1'b0;
    reg_addr_in = '0;
    reg_wdata_in = '0;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    instr_in = '0;
    alu_in = '0;
    known = 1'b1;
    repeat (20) @(posedge clk_in);
    nrst_in <= 1'b1;
    check_regs();
    // unmapped reads give zero, flags and unmapped writes are ignored
    for (int a = 4; a < 8; a++) begin
      reg_read(3'(a), v);
      check("unmapped", v, 8'h00);
    end
    reg_write(3'h5, 8'hFF);
    reg_write(REG_FLAGS, 8'hFF);
    v = 8'(next_rand());
    reg_write(REG_XY, v);
    {my, mx} = v;
    v = 8'(next_rand());
    reg_write(REG_SPARE, v);
    {mys, mxs} = v;
    check_regs();
    // run bit reads back before and after it is set
    reg_read(REG_CTRL, v);
    check("ctrl", v, 8'h00);
    reg_write(REG_CTRL, 8'h01);
    reg_read(REG_CTRL, v);
    check("ctrl", v, 8'h01);
    // every class once; transfers with status forced to 0 and 1
    for (int i = 0; i < 18; i++) begin
      if (op_t'(i) inside {OP_BRANCH, OP_CALL, OP_LOAD_PCU}) begin
        for (int s = 0; s < 2; s++) begin
          exec(OP_TEST_BIT, alu_flags_t'(5'(s << 1)));
          exec(op_t'(i), alu_flags_t'(5'(next_rand())));
        end
      end else begin
        exec(op_t'(i), alu_flags_t'(5'(next_rand())));
      end
    end
    // random stream with register traffic between instructions
    for (int i = 0; i < 40; i++) begin
      op = op_t'(5'(next_rand() % 18));
      if (!known && op inside {OP_BRANCH, OP_CALL, OP_LOAD_PCU}) begin
        op = OP_TEST_BIT;
      end
      exec(op, alu_flags_t'(5'(next_rand())));
      if (i % 8 == 7) begin
        v = 8'(next_rand());
        reg_write(REG_XY, v);
        {my, mx} = v;
        check_regs();
      end
    end
    print_verdict();
  end
endmodule : test_mcu4_instruction_status_control
`default_nettype wire
